// ===== hw/mrs_cfg.svh
// Constants of the reset sequencer: timing, register indices, reset values.
// Included by the sequencer top; holds definitions only.
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

`define MRS_OSC_PER_MC 12
`define MRS_SAMPLE_STATE 5
`define MRS_SAMPLE_PHASE 2
`define MRS_SAMPLE_SLOT ((`MRS_SAMPLE_STATE - 1) * 2 + `MRS_SAMPLE_PHASE - 1)
`define MRS_POR_HOLD_OSC 1536
`define MRS_PCLK_PER_OSC 1
`define MRS_POR_HOLD_CYC (`MRS_POR_HOLD_OSC * `MRS_PCLK_PER_OSC)
`define MRS_OSC_OPTION_FIXED 3
`define MRS_SFR_COUNT 25
`define MRS_PORT_HIGH 8'hFF

`define MRS_IDX_PORT0_LATCH 9'h080
`define MRS_IDX_STACK_POINTER 9'h081
`define MRS_IDX_DATA_POINTER_LOW 9'h082
`define MRS_IDX_DATA_POINTER_HIGH 9'h083
`define MRS_IDX_POWER_CONTROL 9'h087
`define MRS_IDX_TIMER_CTRL_EXT_IRQ 9'h088
`define MRS_IDX_TIMER_MODE_SELECT 9'h089
`define MRS_IDX_TIMER0_LOW_BYTE 9'h08A
`define MRS_IDX_TIMER1_LOW_BYTE 9'h08B
`define MRS_IDX_TIMER0_HIGH_BYTE 9'h08C
`define MRS_IDX_TIMER1_HIGH_BYTE 9'h08D
`define MRS_IDX_PORT1_LATCH 9'h090
`define MRS_IDX_SERIAL_CONTROL 9'h098
`define MRS_IDX_SERIAL_DATA_BUFFER 9'h099
`define MRS_IDX_PORT2_LATCH 9'h0A0
`define MRS_IDX_IRQ_ENABLE_PRIMARY 9'h0A8
`define MRS_IDX_PORT3_LATCH 9'h0B0
`define MRS_IDX_IRQ_PRIORITY_PRIMARY 9'h0B8
`define MRS_IDX_IRQ_REQUEST_FLAGS 9'h0C0
`define MRS_IDX_PROGRAM_STATUS_WORD 9'h0D0
`define MRS_IDX_ACCUMULATOR 9'h0E0
`define MRS_IDX_IRQ_ENABLE_EXTENDED 9'h0E8
`define MRS_IDX_IRQ_POLARITY 9'h0E9
`define MRS_IDX_MULTIPLY_AUX_REGISTER 9'h0F0
`define MRS_IDX_IRQ_PRIORITY_EXTENDED 9'h0F8
`define MRS_IDX_RESET_STATUS 9'h100
`define MRS_IDX_BUILD_CONFIG 9'h101

`define MRS_RST_STACK_POINTER 8'h07
`define MRS_RST_ZERO 8'h00
`define MRS_MASK_ALL 8'hFF
`define MRS_MASK_POWER_CONTROL 8'h9F
`define MRS_MASK_IRQ_PRIORITY_PRIMARY 8'h7F

`define MRS_RAM_AW 7

`endif

// ===== hw/mrs_pkg.sv
// Types shared by the reset sequencer files.
// No dependencies.
package mrs_pkg;
  typedef enum logic [1:0] {MRS_VAR_CUSTOM, MRS_VAR_ROMLESS, MRS_VAR_5V} mrs_variant_t;
  typedef enum logic [1:0] {MRS_PH_POR, MRS_PH_EXT, MRS_PH_RUN} mrs_phase_t;
endpackage : mrs_pkg

// ===== hw/mrs_data_ram.sv
// Internal data RAM, one write port, registered read.
// Has no reset at all, so a core reset never disturbs its contents.
`timescale 1ns/10ps
module mrs_data_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : mrs_data_ram

// ===== hw/mrs_reset_ctl.sv
// Reset sequencer with special function register defaults and data RAM,
// reached over APB. Assumes pclk is the oscillator clock.
// Summary of operation
// RULE_01: Pin held high two machine cycles minimum.
// RULE_02: Sample reset once per cycle, S5P2.
// RULE_03: Reset pin is asynchronous to clock.
// RULE_04: Repeat internal reset while pin samples high.
// RULE_05: Ports take reset level without waiting.
// RULE_06: Both bus strobes held high in reset.
// RULE_07: Reset never alters data RAM contents.
// RULE_08: Power-on hold gates core clock 1536 periods.
// RULE_09: Power-on hold is a build option.
// RULE_10: Port reset level is a build option.
// RULE_11: Fixed variants: ports high, osc 3, no POR.
// RULE_12: Capacitor reset covers startup plus two cycles.
// RULE_13: Reset loads all register defaults.
// RULE_14: Serial buffer unreset; ports take custom pattern.
// RULE_15: Two-flop synchroniser before the sampling point.
// RULE_16: Hold counter restarts when supply drops.
`timescale 1ns/10ps
`include "mrs_cfg.svh"
module mrs_reset_ctl #(
  parameter int unsigned POR_HOLD_CYC = `MRS_POR_HOLD_CYC,
  parameter mrs_pkg::mrs_variant_t VARIANT = mrs_pkg::MRS_VAR_CUSTOM,
  parameter bit POR_ENABLE = 1'b1,
  parameter logic [2:0] OSC_OPTION = 3'(`MRS_OSC_OPTION_FIXED),
  parameter logic [7:0] PORT0_RESET = `MRS_PORT_HIGH,
  parameter logic [7:0] PORT1_RESET = `MRS_PORT_HIGH,
  parameter logic [7:0] PORT2_RESET = `MRS_PORT_HIGH,
  parameter logic [7:0] PORT3_RESET = `MRS_PORT_HIGH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [10:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin,
  input wire logic supply_ok,
  input wire logic core_ale,
  input wire logic core_program_fetch_strobe,
  output logic core_reset,
  output logic core_clk_en,
  output logic address_latch_strobe,
  output logic program_fetch_strobe,
  output logic [7:0] port0_out,
  output logic [7:0] port1_out,
  output logic [7:0] port2_out,
  output logic [7:0] port3_out
);
  import mrs_pkg::*;

  localparam int NREG = `MRS_SFR_COUNT - 1;
  localparam int CW = $clog2(POR_HOLD_CYC + 1);
  // Fixed variants override every build option
  localparam bit FIXED = (VARIANT != MRS_VAR_CUSTOM); // RULE_11
  localparam bit POR_ON = POR_ENABLE && !FIXED; // RULE_09
  localparam logic [2:0] OSC_OPT = FIXED ? 3'(`MRS_OSC_OPTION_FIXED) : OSC_OPTION;
  localparam logic [7:0] PRST0 = FIXED ? `MRS_PORT_HIGH : PORT0_RESET; // RULE_10
  localparam logic [7:0] PRST1 = FIXED ? `MRS_PORT_HIGH : PORT1_RESET; // RULE_10
  localparam logic [7:0] PRST2 = FIXED ? `MRS_PORT_HIGH : PORT2_RESET; // RULE_10
  localparam logic [7:0] PRST3 = FIXED ? `MRS_PORT_HIGH : PORT3_RESET; // RULE_10
  localparam int S_P0 = 0;
  localparam int S_P1 = 11;
  localparam int S_P2 = 13;
  localparam int S_P3 = 15;

  localparam logic [8:0] SFR_IDX [NREG] = '{
    `MRS_IDX_PORT0_LATCH, `MRS_IDX_STACK_POINTER,
    `MRS_IDX_DATA_POINTER_LOW, `MRS_IDX_DATA_POINTER_HIGH,
    `MRS_IDX_POWER_CONTROL, `MRS_IDX_TIMER_CTRL_EXT_IRQ,
    `MRS_IDX_TIMER_MODE_SELECT, `MRS_IDX_TIMER0_LOW_BYTE,
    `MRS_IDX_TIMER1_LOW_BYTE, `MRS_IDX_TIMER0_HIGH_BYTE,
    `MRS_IDX_TIMER1_HIGH_BYTE, `MRS_IDX_PORT1_LATCH,
    `MRS_IDX_SERIAL_CONTROL, `MRS_IDX_PORT2_LATCH,
    `MRS_IDX_IRQ_ENABLE_PRIMARY, `MRS_IDX_PORT3_LATCH,
    `MRS_IDX_IRQ_PRIORITY_PRIMARY, `MRS_IDX_IRQ_REQUEST_FLAGS,
    `MRS_IDX_PROGRAM_STATUS_WORD, `MRS_IDX_ACCUMULATOR,
    `MRS_IDX_IRQ_ENABLE_EXTENDED, `MRS_IDX_IRQ_POLARITY,
    `MRS_IDX_MULTIPLY_AUX_REGISTER, `MRS_IDX_IRQ_PRIORITY_EXTENDED
  };

  // Defaults, with the port slots taking the build pattern
  localparam logic [7:0] SFR_RST [NREG] = '{ // RULE_13
    PRST0, `MRS_RST_STACK_POINTER, `MRS_RST_ZERO, `MRS_RST_ZERO,
    `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO,
    `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO, PRST1,
    `MRS_RST_ZERO, PRST2, `MRS_RST_ZERO, PRST3,
    `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO,
    `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO, `MRS_RST_ZERO
  };

  // Undefined bits are held at zero so reads stay deterministic
  localparam logic [7:0] SFR_MASK [NREG] = '{
    `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL,
    `MRS_MASK_POWER_CONTROL, `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL,
    `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL,
    `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL,
    `MRS_MASK_IRQ_PRIORITY_PRIMARY, `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL,
    `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL, `MRS_MASK_ALL
  };

  // Synchronisers
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic sup_meta_reg;
  logic sup_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
      sup_meta_reg <= 1'b0;
      sup_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= reset_pin; // RULE_03
      rst_sync_reg <= rst_meta_reg; // RULE_15
      sup_meta_reg <= supply_ok;
      sup_sync_reg <= sup_meta_reg;
    end
  end

  // Sequencer state
  logic [3:0] slot_reg;
  logic [3:0] slot_next;
  logic ext_rst_reg;
  logic ext_rst_next;
  logic [CW-1:0] por_cnt_reg;
  logic [CW-1:0] por_cnt_next;
  logic por_hold_reg;
  logic por_hold_next;
  logic core_rst_next;
  logic port_force_reg;
  logic port_force_next;
  logic clk_en_next;
  logic ale_next;
  logic program_fetch_strobe_next;
  mrs_phase_t phase_reg;
  mrs_phase_t phase_next;

  always_comb begin
    slot_next = (slot_reg == 4'(`MRS_OSC_PER_MC - 1)) ? 4'h0 : slot_reg + 4'h1;
    ext_rst_next = ext_rst_reg;
    if (slot_reg == 4'(`MRS_SAMPLE_SLOT)) begin
      ext_rst_next = rst_sync_reg; // RULE_02 RULE_04
    end
    por_cnt_next = por_cnt_reg;
    por_hold_next = por_hold_reg;
    if (!POR_ON) begin
      por_hold_next = 1'b0; // RULE_09
      por_cnt_next = '0;
    end else if (!sup_sync_reg) begin
      por_hold_next = 1'b1; // RULE_16
      por_cnt_next = '0;
    end else if (por_hold_reg) begin
      if (por_cnt_reg == CW'(POR_HOLD_CYC - 1)) begin
        por_hold_next = 1'b0; // RULE_08
      end else begin
        por_cnt_next = por_cnt_reg + CW'(1);
      end
    end
    core_rst_next = ext_rst_next | por_hold_next; // RULE_08
    // Pin level acts before the sampling point
    port_force_next = rst_sync_reg | core_rst_next; // RULE_05
    clk_en_next = !por_hold_next; // RULE_08
    ale_next = core_rst_next | core_ale; // RULE_06
    program_fetch_strobe_next = core_rst_next | core_program_fetch_strobe; // RULE_06
    case (1'b1)
      por_hold_next: phase_next = MRS_PH_POR;
      core_rst_next: phase_next = MRS_PH_EXT;
      default: phase_next = MRS_PH_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_reg <= 4'h0;
      ext_rst_reg <= 1'b0;
      por_cnt_reg <= '0;
      por_hold_reg <= POR_ON;
      core_reset <= 1'b1;
      port_force_reg <= 1'b1;
      core_clk_en <= !POR_ON;
      address_latch_strobe <= 1'b1;
      program_fetch_strobe <= 1'b1;
      phase_reg <= MRS_PH_EXT;
    end else begin
      slot_reg <= slot_next;
      ext_rst_reg <= ext_rst_next;
      por_cnt_reg <= por_cnt_next;
      por_hold_reg <= por_hold_next;
      core_reset <= core_rst_next;
      port_force_reg <= port_force_next;
      core_clk_en <= clk_en_next;
      address_latch_strobe <= ale_next;
      program_fetch_strobe <= program_fetch_strobe_next;
      phase_reg <= phase_next;
    end
  end

  // APB decode
  logic [8:0] idx;
  logic setup;
  logic done;
  logic ram_hit;
  logic sbuf_hit;
  logic stat_hit;
  logic cfg_hit;
  logic sfr_hit;
  logic [4:0] sfr_sel;
  logic [7:0] ram_rdata;

  assign idx = paddr[10:2];
  assign setup = psel & ~penable;
  assign done = psel & penable & pready;
  assign ram_hit = (idx[8:7] == 2'b00);
  assign sbuf_hit = (idx == `MRS_IDX_SERIAL_DATA_BUFFER);
  assign stat_hit = (idx == `MRS_IDX_RESET_STATUS);
  assign cfg_hit = (idx == `MRS_IDX_BUILD_CONFIG);

  always_comb begin
    sfr_hit = 1'b0;
    sfr_sel = 5'h00;
    for (int i = 0; i < NREG; i++) begin
      if (idx == SFR_IDX[i]) begin
        sfr_hit = 1'b1;
        sfr_sel = 5'(i);
      end
    end
  end

  // Reads are issued in setup so RAM data is ready in access
  mrs_data_ram #(
    .AW(`MRS_RAM_AW),
    .DW(8)
  ) u_ram (
    .clk(pclk),
    .we(done & pwrite & ram_hit), // RULE_07
    .addr(idx[`MRS_RAM_AW-1:0]),
    .wdata(pwdata[7:0]),
    .rdata(ram_rdata)
  );

  // Special function registers
  logic [7:0] sfr_reg [NREG];
  logic [7:0] sfr_next [NREG];
  logic [7:0] sbuf_reg;
  logic [7:0] sbuf_next;

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      sfr_next[i] = sfr_reg[i];
      if (core_reset) begin
        sfr_next[i] = SFR_RST[i]; // RULE_13 RULE_14
      end else if (done && pwrite && sfr_hit && sfr_sel == 5'(i)) begin
        sfr_next[i] = pwdata[7:0] & SFR_MASK[i];
      end
    end
    sbuf_next = sbuf_reg;
    if (done && pwrite && sbuf_hit) begin
      sbuf_next = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        sfr_reg[i] <= SFR_RST[i]; // RULE_13
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        sfr_reg[i] <= sfr_next[i];
      end
    end
  end

  // Serial buffer is deliberately left out of every reset
  always_ff @(posedge pclk) begin
    sbuf_reg <= sbuf_next; // RULE_14
  end

  // Port pins
  logic [7:0] p0_next;
  logic [7:0] p1_next;
  logic [7:0] p2_next;
  logic [7:0] p3_next;

  always_comb begin
    p0_next = port_force_next ? PRST0 : sfr_reg[S_P0]; // RULE_05 RULE_14
    p1_next = port_force_next ? PRST1 : sfr_reg[S_P1]; // RULE_05 RULE_14
    p2_next = port_force_next ? PRST2 : sfr_reg[S_P2]; // RULE_05 RULE_14
    p3_next = port_force_next ? PRST3 : sfr_reg[S_P3]; // RULE_05 RULE_14
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_out <= PRST0;
      port1_out <= PRST1;
      port2_out <= PRST2;
      port3_out <= PRST3;
    end else begin
      port0_out <= p0_next;
      port1_out <= p1_next;
      port2_out <= p2_next;
      port3_out <= p3_next;
    end
  end

  // APB answer: one wait state, pready from a flop
  logic pready_next;
  logic pslverr_next;
  logic [31:0] prdata_next;
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (ram_hit) begin
      rd_byte = ram_rdata;
    end else if (sfr_hit) begin
      rd_byte = sfr_reg[sfr_sel];
    end else if (sbuf_hit) begin
      rd_byte = sbuf_reg;
    end else if (stat_hit) begin
      rd_byte = {2'b00, phase_reg, rst_sync_reg, ext_rst_reg, por_hold_reg, core_reset};
    end else if (cfg_hit) begin
      rd_byte = {VARIANT, 2'b00, POR_ON, OSC_OPT};
    end
    pready_next = psel & penable & ~pready;
    prdata_next = pready_next ? {24'h000000, rd_byte} : 32'h00000000;
    pslverr_next = pready_next & ~(ram_hit | sfr_hit | sbuf_hit | stat_hit | cfg_hit);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= pready_next;
      pslverr <= pslverr_next;
      prdata <= prdata_next;
    end
  end

  // Setup term kept for readability of the read path timing
  logic unused_setup;
  assign unused_setup = setup;
endmodule : mrs_reset_ctl

// ===== tb/mrs_reset_ctl_monitor.sv
// Checker for the reset sequencer, bound to its top module.
// Assumes all-high port reset patterns and the power-on hold built in.
`timescale 1ns/10ps
module mrs_reset_ctl_monitor #(
  parameter int unsigned POR_HOLD_CYC = 1536
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic reset_pin,
  input wire logic supply_ok,
  input wire logic core_ale,
  input wire logic core_program_fetch_strobe,
  input wire logic core_reset,
  input wire logic core_clk_en,
  input wire logic address_latch_strobe,
  input wire logic program_fetch_strobe,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port2_out,
  input wire logic [7:0] port3_out
);
  int pin_cnt;
  int sup_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Run lengths, saturated so long runs never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt <= 0;
      sup_cnt <= 0;
    end else begin
      pin_cnt <= reset_pin ? ((pin_cnt < 99) ? pin_cnt + 1 : pin_cnt) : 0;
      sup_cnt <= supply_ok ? ((sup_cnt < 99999) ? sup_cnt + 1 : sup_cnt) : 0;
    end
  end
  property p_strobe_rst;
    core_reset |-> address_latch_strobe && program_fetch_strobe;
  endproperty
  a_strobe_rst: assert property (p_strobe_rst)
    else $error("strobe low in reset");
  property p_strobe_pass;
    !core_reset |-> address_latch_strobe == $past(core_ale)
      && program_fetch_strobe == $past(core_program_fetch_strobe);
  endproperty
  a_strobe_pass: assert property (p_strobe_pass)
    else $error("strobe not passed through");
  property p_clk_hold;
    !core_clk_en |-> core_reset;
  endproperty
  a_clk_hold: assert property (p_clk_hold)
    else $error("core out of reset during hold");
  property p_por_early;
    $rose(core_clk_en) |-> sup_cnt >= POR_HOLD_CYC;
  endproperty
  a_por_early: assert property (p_por_early)
    else $error("hold released early");
  property p_por_late;
    sup_cnt >= POR_HOLD_CYC + 5 |-> core_clk_en;
  endproperty
  a_por_late: assert property (p_por_late)
    else $error("hold released late");
  // Slack covers two sync stages plus one machine cycle
  property p_pin_hold;
    pin_cnt >= 18 |-> core_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("reset not repeated while pin high");
  property p_ports;
    $rose(reset_pin) |-> ##[1:4] ({port0_out, port1_out, port2_out, port3_out} == 32'hFFFFFFFF);
  endproperty
  a_ports: assert property (p_ports)
    else $error("ports slow to reset level");
  property p_apb_wait;
    psel && $rose(penable) |-> !pready ##1 pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("register bus wait state wrong");
  c_run: cover property ($fell(core_reset));
  c_pin: cover property ($rose(reset_pin));
  c_drop: cover property ($fell(core_clk_en));
endmodule : mrs_reset_ctl_monitor

bind mrs_reset_ctl mrs_reset_ctl_monitor #(.POR_HOLD_CYC(POR_HOLD_CYC)) u_mon (
  .pclk, .presetn, .psel, .penable, .pready, .reset_pin, .supply_ok, .core_ale,
  .core_program_fetch_strobe, .core_reset, .core_clk_en, .address_latch_strobe, .program_fetch_strobe,
  .port0_out, .port1_out, .port2_out, .port3_out
);

// ===== tb/mrs_reset_src.sv
// External reset circuit and supply detector facing the sequencer pins.
// The bench commands pulse length and supply loss.
`timescale 1ns/10ps
module mrs_reset_src (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic drop,
  output logic reset_pin,
  output logic supply_ok
);
  logic [7:0] cnt;
  initial begin
    reset_pin = 1'b0;
    supply_ok = 1'b1;
    cnt = 8'h00;
  end
  // Pulse is len cycles; below 24 it is not a valid reset
  always @(posedge pclk) begin
    supply_ok <= !drop;
    cnt <= go ? len : ((cnt != 8'h00) ? cnt - 8'h01 : cnt);
    reset_pin <= go || (cnt > 8'h01);
  end
endmodule : mrs_reset_src

// ===== tb/test_mrs_reset_ctl.sv
// Self-checking bench for the reset sequencer over its register bus.
// Short power-on hold of 16 cycles; default all-high port patterns.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_mrs_reset_ctl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [10:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [31:0] prdata2, rdata2;
  logic rst2, clk_en2;
  logic [7:0] p1b;
  logic core_ale, core_program_fetch_strobe, core_reset, core_clk_en, ale_s, fetch_s;
  logic reset_pin, supply_ok, go, drop;
  logic [7:0] len, p0, p1, p2, p3;
  int checks, mismatches, cyc, n;
  logic [8:0] idx [25] = '{9'h080, 9'h081, 9'h082, 9'h083, 9'h087, 9'h088, 9'h089,
    9'h08A, 9'h08B, 9'h08C, 9'h08D, 9'h090, 9'h098, 9'h099, 9'h0A0, 9'h0A8, 9'h0B0,
    9'h0B8, 9'h0C0, 9'h0D0, 9'h0E0, 9'h0E8, 9'h0E9, 9'h0F0, 9'h0F8};

  mrs_reset_ctl #(.POR_HOLD_CYC(16)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin(reset_pin), .supply_ok(supply_ok),
    .core_ale(core_ale), .core_program_fetch_strobe(core_program_fetch_strobe), .core_reset(core_reset),
    .core_clk_en(core_clk_en), .address_latch_strobe(ale_s),
    .program_fetch_strobe(fetch_s), .port0_out(p0), .port1_out(p1),
    .port2_out(p2), .port3_out(p3)
  );
  mrs_reset_src u_src (
    .pclk(pclk), .go(go), .len(len), .drop(drop), .reset_pin(reset_pin),
    .supply_ok(supply_ok)
  );
  // Fixed build: custom port pattern must be overridden, no power-on hold
  mrs_reset_ctl #(.POR_HOLD_CYC(16), .VARIANT(mrs_pkg::MRS_VAR_ROMLESS),
    .PORT1_RESET(8'h3C)) u_fixed (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata2), .pready(), .pslverr(),
    .reset_pin(reset_pin), .supply_ok(supply_ok), .core_ale(core_ale),
    .core_program_fetch_strobe(core_program_fetch_strobe), .core_reset(rst2), .core_clk_en(clk_en2),
    .address_latch_strobe(), .program_fetch_strobe(), .port0_out(), .port1_out(p1b),
    .port2_out(), .port3_out()
  );

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    core_ale <= ~core_ale;
    core_program_fetch_strobe <= core_ale;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  function automatic logic [7:0] rst_of(input int i, input logic [7:0] sbuf);
    case (i)
      0, 11, 14, 16: return 8'hFF;
      1: return 8'h07;
      13: return sbuf;
      default: return 8'h00;
    endcase
  endfunction : rst_of

  // One transfer; request held until the rising edge that samples pready high
  task automatic apb(input logic w, input logic [8:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    rdata2 = prdata2;
    rerr = pslverr;
    if (k >= 50) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("sfr", {24'h000000, e}, rdata)
  endtask : rd_chk

  task automatic wait_run;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (core_reset !== 1'b0 && n < 500);
    if (n >= 500) mismatches++;
  endtask : wait_run

  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial begin
    {pclk, presetn, psel, penable, pwrite, core_ale, core_program_fetch_strobe, go, drop} = '0;
    paddr = 11'h000;
    pwdata = 32'h00000000;
    len = 8'h28;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    `CHK("clk_en", 1'b1, core_clk_en)
    `CHK("fixed", 10'h2FF, {clk_en2, rst2, p1b})
    for (int i = 0; i < 25; i++) rd_chk(idx[i], rst_of(i, 8'hXX));
    rd_chk(9'h101, 8'h0B);
    `CHK("fixed_cfg", 32'h00000043, rdata2)
    for (int i = 0; i < 25; i++) apb(1'b1, idx[i], 8'hA5);
    for (int i = 0; i < 25; i++) rd_chk(idx[i], (i == 4) ? 8'h85 : (i == 17) ? 8'h25 : 8'hA5);
    apb(1'b1, 9'h005, 8'h3C);
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("ports", 32'hFFFFFFFF, {p0, p1, p2, p3})
    repeat (16) @(posedge pclk);
    `CHK("in_reset", 3'h7, {core_reset, ale_s, fetch_s})
    apb(1'b1, 9'h081, 8'h33);
    rd_chk(9'h081, 8'h07);
    wait_run();
    for (int i = 0; i < 25; i++) rd_chk(idx[i], rst_of(i, 8'hA5));
    rd_chk(9'h005, 8'h3C);
    apb(1'b0, 9'h084, 8'h00);
    `CHK("unmapped", 33'h100000000, {rerr, rdata})
    drop <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("por_hold", 2'h1, {core_clk_en, core_reset})
    `CHK("no_por", 2'h2, {clk_en2, rst2})
    drop <= 1'b0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (core_clk_en !== 1'b1 && n < 100);
    `CHK("por_len", 1'b1, n >= 17 && n <= 23)
    wait_run();
    rd_chk(9'h081, 8'h07);
    end_sim();
  end
endmodule : test_mrs_reset_ctl
